// ==== design/sfr_pkg.sv ====
/*
  shared constants, opcodes, status layout and state codes of the serial flash
  read and status-write front end.
  assumes a 10 MHz system clock and a host-driven serial clock far below it.
*/
package sfr_pkg;

  localparam int unsigned CLK_PERIOD_NS        = 100;
  // time of the self-timed status write cycle, in ns
  localparam int unsigned STATUS_WRITE_TIME_NS = 15000000;
  localparam int unsigned STATUS_WRITE_CYCLES  = (STATUS_WRITE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  localparam int unsigned FIFO_DEPTH = 16;
  localparam int unsigned FIFO_WIDTH = 8;

  localparam logic [7:0] OP_WRITE_STATUS = 8'h01;
  localparam logic [7:0] OP_READ         = 8'h03;
  localparam logic [7:0] OP_FAST_READ    = 8'h0B;
  localparam logic [7:0] OP_DUAL_OUT     = 8'h3B;
  localparam logic [7:0] OP_QUAD_OUT     = 8'h6B;
  localparam logic [7:0] OP_DUAL_IO      = 8'hBB;
  localparam logic [7:0] OP_STATUS_LO    = 8'h05;
  localparam logic [7:0] OP_STATUS_HI    = 8'h35;

  localparam logic [3:0] CONT_MODE_KEY = 4'hA;

  localparam logic [15:0] STATUS_RESET    = 16'h0000;
  localparam logic [15:0] STATUS_WRITABLE = 16'h03FC;
  localparam int unsigned BUSY_BIT        = 0;
  localparam int unsigned WEL_BIT         = 1;

  localparam logic [4:0] CMD_LAST         = 5'h07;
  localparam logic [4:0] ADDR_LAST_SINGLE = 5'h17;
  localparam logic [4:0] ADDR_LAST_DUAL   = 5'h0B;
  localparam logic [4:0] MODE_LAST        = 5'h03;
  localparam logic [4:0] DUMMY_LAST       = 5'h07;
  localparam logic [4:0] SWR_SHORT_BITS   = 5'h08;
  localparam logic [4:0] SWR_LONG_BITS    = 5'h10;
  localparam logic [4:0] CNT_SATURATE     = 5'h1F;

  localparam logic [1:0] LANES_SINGLE = 2'h0;
  localparam logic [1:0] LANES_DUAL   = 2'h1;
  localparam logic [1:0] LANES_QUAD   = 2'h2;

  typedef struct packed {
    logic [5:0] reserved;
    logic       quad_enable_bit;
    logic       status_protect_hi;
    logic       status_protect_lo;
    logic       sector_granularity_select;
    logic       top_bottom_select;
    logic       block_protect_2;
    logic       block_protect_1;
    logic       block_protect_0;
    logic       write_enable_latch;
    logic       busy;
  } sfr_status_type;

  typedef struct packed {
    logic       sclk;
    logic       cs_n;
    logic [3:0] data;
  } sfr_pins_type;

  typedef enum logic [7:0] {
    ST_IDLE  = 8'h01,
    ST_CMD   = 8'h02,
    ST_ADDR  = 8'h04,
    ST_MODE  = 8'h08,
    ST_DUMMY = 8'h10,
    ST_DATA  = 8'h20,
    ST_SWR   = 8'h40,
    ST_SKIP  = 8'h80
  } sfr_state_type;

endpackage

// ==== design/sfr_fifo.sv ====
/*
  synchronous fifo with valid/ready on both sides and a flush input.
  assumes one clock; depth a power of two, at least two.
*/
`timescale 1ns/1ns
module sfr_fifo #(
  parameter int unsigned WIDTH = 8,
  parameter int unsigned DEPTH = 16
) (
  input  wire logic             clk,
  input  wire logic             rst,
  input  wire logic             clear,
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic [WIDTH-1:0]      out_data
);
  localparam int unsigned AW = $clog2(DEPTH);

  if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0 || WIDTH < 1) begin : g_bad_size
    $error("fifo depth must be a power of two of at least two");
  end

  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [AW:0]      wr_q;
  logic [AW:0]      rd_q;
  wire  [AW:0]      fill = wr_q - rd_q;
  wire              push = in_valid & in_ready;
  wire              pop  = out_valid & out_ready;

  assign in_ready  = fill != (AW + 1)'(DEPTH);
  assign out_valid = fill != '0;
  assign out_data  = mem_q[rd_q[AW-1:0]];

  always_ff @(posedge clk) begin
    if (push) begin
      mem_q[wr_q[AW-1:0]] <= in_data;
    end
  end

  always_ff @(posedge clk) begin
    if (rst || clear) begin
      wr_q <= '0;
      rd_q <= '0;
    end else begin
      if (push) begin
        wr_q <= wr_q + 1'b1;
      end
      if (pop) begin
        rd_q <= rd_q + 1'b1;
      end
    end
  end
endmodule

// ==== design/sfr_core.sv ====
/*
  serial flash front end: status write and the single, fast, dual, quad and
  dual-io read family with continuous read mode.
  assumes host-driven serial clock (mode 0) at most an eighth of clk; memory
  answers rd_req with rd_ack on clk; other writers report through ext_busy.
*/
`timescale 1ns/1ns
module sfr_core #(
  parameter int unsigned WRITE_CYCLES = sfr_pkg::STATUS_WRITE_CYCLES,
  parameter int unsigned FIFO_DEPTH   = sfr_pkg::FIFO_DEPTH
) (
  input  wire logic               clk,
  input  wire logic               rst,
  input  wire logic               sclk_pin,
  input  wire logic               cs_n_pin,
  input  wire logic [3:0]         data_line_in,
  output logic [3:0]              data_line_out,
  output logic [3:0]              data_line_oe,
  input  wire logic               write_enable_set,
  input  wire logic               ext_busy,
  output sfr_pkg::sfr_status_type status_out,
  output logic                    cont_mode_active,
  output logic                    rd_req,
  output logic [23:0]             rd_addr,
  input  wire logic               rd_ack,
  input  wire logic [7:0]         rd_data
);
  localparam int unsigned TW = $clog2(WRITE_CYCLES + 1);

  if (WRITE_CYCLES < 2) begin : g_bad_time
    $error("write cycle count must be at least two");
  end

  // pin synchroniser; stage one feeds stage two only
  sfr_pkg::sfr_pins_type pin1_q;
  sfr_pkg::sfr_pins_type pin2_q;
  logic                  sclk_prev_q;
  logic                  cs_n_prev_q;

  always_ff @(posedge clk) begin
    if (rst) begin
      pin1_q      <= '{sclk: 1'b0, cs_n: 1'b1, data: 4'h0};
      pin2_q      <= '{sclk: 1'b0, cs_n: 1'b1, data: 4'h0};
      sclk_prev_q <= 1'b0;
      cs_n_prev_q <= 1'b1;
    end else begin
      pin1_q      <= '{sclk: sclk_pin, cs_n: cs_n_pin, data: data_line_in};
      pin2_q      <= pin1_q;
      sclk_prev_q <= pin2_q.sclk;
      cs_n_prev_q <= pin2_q.cs_n;
    end
  end

  wire       cs_low  = ~pin2_q.cs_n;
  wire       rise    = cs_low & pin2_q.sclk & ~sclk_prev_q;
  wire       fall    = cs_low & ~pin2_q.sclk & sclk_prev_q;
  wire       cs_fall = cs_low & cs_n_prev_q;
  wire       cs_rise = ~cs_low & ~cs_n_prev_q;
  wire [3:0] din     = pin2_q.data;

  sfr_pkg::sfr_state_type state_q;
  sfr_pkg::sfr_state_type state_d;
  logic [4:0]  cnt_q;
  logic [4:0]  cnt_d;
  logic [7:0]  cmd_q;
  logic [23:0] addr_q;
  logic [7:0]  mode_q;
  logic [15:0] swr_q;
  logic        dual_in_q;
  logic        dummy_q;
  logic        stat_rd_q;
  logic [1:0]  lanes_q;
  logic [7:0]  sh_q;
  logic [2:0]  beat_q;
  logic [3:0]  out_q;
  logic [3:0]  oe_q;
  logic [15:0] status_q;
  logic [TW-1:0] wr_cnt_q;
  logic        cont_q;
  logic [23:0] rd_addr_q;
  logic        stream_q;

  // data lanes used by an opcode; called once, at the end of decode
  function automatic logic [1:0] op_lanes(input logic [7:0] op);
    logic [1:0] l;
    l = sfr_pkg::LANES_SINGLE;
    if (op == sfr_pkg::OP_DUAL_OUT || op == sfr_pkg::OP_DUAL_IO) begin
      l = sfr_pkg::LANES_DUAL;
    end else if (op == sfr_pkg::OP_QUAD_OUT) begin
      l = sfr_pkg::LANES_QUAD;
    end
    return l;
  endfunction

  // opcode decode, complete on the eighth rising edge
  wire [7:0] op        = {cmd_q[6:0], din[0]};
  wire       wr_busy   = wr_cnt_q != '0;
  wire       busy      = wr_busy | ext_busy;
  wire       op_single = op == sfr_pkg::OP_READ || op == sfr_pkg::OP_FAST_READ || op == sfr_pkg::OP_DUAL_OUT;
  wire       op_quad   = op == sfr_pkg::OP_QUAD_OUT;
  wire       op_dio    = op == sfr_pkg::OP_DUAL_IO;
  wire       op_stat   = op == sfr_pkg::OP_STATUS_LO || op == sfr_pkg::OP_STATUS_HI;
  wire       op_swr    = op == sfr_pkg::OP_WRITE_STATUS;
  wire       quad_ok   = status_q[9];
  wire       read_go   = ~busy & (op_single | op_dio | (op_quad & quad_ok));
  wire       cmd_done  = rise & (state_q == sfr_pkg::ST_CMD) & (cnt_q == sfr_pkg::CMD_LAST);

  wire sfr_pkg::sfr_state_type after_cmd =
    read_go ? sfr_pkg::ST_ADDR :
    op_stat ? sfr_pkg::ST_DATA :
    op_swr  ? sfr_pkg::ST_SWR  : sfr_pkg::ST_SKIP;

  // address and mode capture, one or two bits per rising edge
  wire [23:0] addr_next = dual_in_q ? {addr_q[21:0], din[1:0]} : {addr_q[22:0], din[0]};
  wire [7:0]  mode_next = {mode_q[5:0], din[1:0]};
  wire        addr_last = cnt_q == (dual_in_q ? sfr_pkg::ADDR_LAST_DUAL : sfr_pkg::ADDR_LAST_SINGLE);
  wire        addr_done = rise & (state_q == sfr_pkg::ST_ADDR) & addr_last;
  wire        mode_done = rise & (state_q == sfr_pkg::ST_MODE) & (cnt_q == sfr_pkg::MODE_LAST);

  wire sfr_pkg::sfr_state_type after_addr =
    dual_in_q ? sfr_pkg::ST_MODE : (dummy_q ? sfr_pkg::ST_DUMMY : sfr_pkg::ST_DATA);

  always_comb begin
    state_d = state_q;
    cnt_d   = cnt_q;
    if (cs_fall) begin
      state_d = cont_q ? sfr_pkg::ST_ADDR : sfr_pkg::ST_CMD;
      cnt_d   = '0;
    end else if (!cs_low) begin
      state_d = sfr_pkg::ST_IDLE;
      cnt_d   = '0;
    end else if (rise) begin
      cnt_d = cnt_q + 5'h01;
      case (state_q)
        sfr_pkg::ST_CMD: begin
          if (cnt_q == sfr_pkg::CMD_LAST) begin
            state_d = after_cmd;
            cnt_d   = '0;
          end
        end
        sfr_pkg::ST_ADDR: begin
          if (addr_last) begin
            state_d = after_addr;
            cnt_d   = '0;
          end
        end
        sfr_pkg::ST_MODE: begin
          if (cnt_q == sfr_pkg::MODE_LAST) begin
            state_d = sfr_pkg::ST_DATA;
            cnt_d   = '0;
          end
        end
        sfr_pkg::ST_DUMMY: begin
          if (cnt_q == sfr_pkg::DUMMY_LAST) begin
            state_d = sfr_pkg::ST_DATA;
            cnt_d   = '0;
          end
        end
        sfr_pkg::ST_SWR: begin
          if (cnt_q == sfr_pkg::CNT_SATURATE) begin
            cnt_d = cnt_q;
          end
        end
        default: begin
          cnt_d = cnt_q;
        end
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      state_q <= sfr_pkg::ST_IDLE;
      cnt_q   <= '0;
    end else begin
      state_q <= state_d;
      cnt_q   <= cnt_d;
    end
  end

  // frame attributes; a continuous frame behaves as a dual-io read
  always_ff @(posedge clk) begin
    if (rst) begin
      cmd_q     <= 8'h00;
      dual_in_q <= 1'b0;
      dummy_q   <= 1'b0;
      stat_rd_q <= 1'b0;
      lanes_q   <= sfr_pkg::LANES_SINGLE;
    end else if (cs_fall) begin
      cmd_q     <= cont_q ? sfr_pkg::OP_DUAL_IO : 8'h00;
      dual_in_q <= cont_q;
      dummy_q   <= 1'b0;
      stat_rd_q <= 1'b0;
      lanes_q   <= cont_q ? sfr_pkg::LANES_DUAL : sfr_pkg::LANES_SINGLE;
    end else if (rise && state_q == sfr_pkg::ST_CMD) begin
      cmd_q <= op;
      if (cmd_done) begin
        dual_in_q <= op_dio;
        dummy_q   <= ~op_dio & (op != sfr_pkg::OP_READ);
        stat_rd_q <= op_stat;
        lanes_q   <= op_lanes(op);
      end
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      addr_q <= 24'h000000;
      mode_q <= 8'h00;
      swr_q  <= 16'h0000;
    end else if (cs_fall) begin
      swr_q <= 16'h0000;
    end else if (rise) begin
      if (state_q == sfr_pkg::ST_ADDR) begin
        addr_q <= addr_next;
      end
      if (state_q == sfr_pkg::ST_MODE) begin
        mode_q <= mode_next;
      end
      if (state_q == sfr_pkg::ST_SWR) begin
        swr_q <= {swr_q[14:0], din[0]};
      end
    end
  end

  // only the upper mode nibble decides; lower nibble is don't care
  always_ff @(posedge clk) begin
    if (rst) begin
      cont_q <= 1'b0;
    end else if (mode_done) begin
      cont_q <= mode_next[7:4] == sfr_pkg::CONT_MODE_KEY;
    end
  end

  // prefetch into the fifo; the memory may stall by holding off rd_ack
  logic       fifo_in_ready;
  logic       fifo_out_valid;
  logic [7:0] fifo_out_data;
  wire        push      = rd_req & rd_ack;
  wire        in_data   = state_q == sfr_pkg::ST_DATA;
  wire        byte_edge = fall & in_data & (beat_q == 3'h0);
  wire        pop       = byte_edge & ~stat_rd_q;

  assign rd_req  = stream_q & cs_low & fifo_in_ready;
  assign rd_addr = rd_addr_q;

  always_ff @(posedge clk) begin
    if (rst) begin
      stream_q  <= 1'b0;
      rd_addr_q <= 24'h000000;
    end else if (!cs_low) begin
      stream_q <= 1'b0;
    end else if (addr_done) begin
      stream_q  <= 1'b1;
      rd_addr_q <= addr_next;
    end else if (push) begin
      rd_addr_q <= rd_addr_q + 24'h000001;
    end
  end

  sfr_fifo #(
    .WIDTH (sfr_pkg::FIFO_WIDTH),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .clk       (clk),
    .rst       (rst),
    .clear     (addr_done | ~cs_low),
    .in_valid  (push),
    .in_ready  (fifo_in_ready),
    .in_data   (rd_data),
    .out_valid (fifo_out_valid),
    .out_ready (pop),
    .out_data  (fifo_out_data)
  );

  // output serialiser; an empty fifo shows zero rather than stale data
  wire        quad      = lanes_q == sfr_pkg::LANES_QUAD;
  wire        dual      = lanes_q == sfr_pkg::LANES_DUAL;
  wire [7:0]  stat_byte = (cmd_q == sfr_pkg::OP_STATUS_HI) ? status_out[15:8] : status_out[7:0];
  wire [7:0]  mem_byte  = fifo_out_valid ? fifo_out_data : 8'h00;
  wire [7:0]  cur_byte  = (beat_q != 3'h0) ? sh_q : (stat_rd_q ? stat_byte : mem_byte);
  wire [3:0]  lane_val  = quad ? cur_byte[7:4] : dual ? {2'b00, cur_byte[7:6]} : {2'b00, cur_byte[7], 1'b0};
  wire [3:0]  lane_en   = quad ? 4'hF : dual ? 4'h3 : 4'h2;
  wire [7:0]  sh_next   = quad ? {cur_byte[3:0], 4'h0} : dual ? {cur_byte[5:0], 2'b00} : {cur_byte[6:0], 1'b0};
  wire        beat_last = beat_q == (quad ? 3'h1 : dual ? 3'h3 : 3'h7);

  always_ff @(posedge clk) begin
    if (rst || !cs_low || !in_data) begin
      beat_q <= 3'h0;
      sh_q   <= 8'h00;
    end else if (fall) begin
      beat_q <= beat_last ? 3'h0 : beat_q + 3'h1;
      sh_q   <= sh_next;
    end
  end

  // lines stay released through dummies and mode bits
  always_ff @(posedge clk) begin
    if (rst || !cs_low) begin
      out_q <= 4'h0;
      oe_q  <= 4'h0;
    end else if (fall && in_data) begin
      out_q <= lane_val;
      oe_q  <= lane_en;
    end
  end

  assign data_line_out = out_q;
  assign data_line_oe  = oe_q;

  // status write: judged at the select rise, the bit count saturates at 31
  wire        swr_end    = cs_rise & (state_q == sfr_pkg::ST_SWR);
  wire        swr_short  = cnt_q == sfr_pkg::SWR_SHORT_BITS;
  wire        swr_long   = cnt_q == sfr_pkg::SWR_LONG_BITS;
  wire        swr_commit = swr_end & status_q[sfr_pkg::WEL_BIT] & ~busy & (swr_short | swr_long);
  wire [15:0] swr_val    = swr_long ? {swr_q[7:0], swr_q[15:8]} : {8'h00, swr_q[7:0]};
  wire        wr_done    = wr_cnt_q == TW'(1);

  always_ff @(posedge clk) begin
    if (rst) begin
      status_q <= sfr_pkg::STATUS_RESET;
    end else begin
      if (swr_commit) begin
        status_q <= (status_q & ~sfr_pkg::STATUS_WRITABLE) | (swr_val & sfr_pkg::STATUS_WRITABLE);
      end
      // a new enable in the finishing cycle wins over the clear
      if (write_enable_set) begin
        status_q[sfr_pkg::WEL_BIT] <= 1'b1;
      end else if (wr_done) begin
        status_q[sfr_pkg::WEL_BIT] <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      wr_cnt_q <= '0;
    end else if (swr_commit) begin
      wr_cnt_q <= TW'(WRITE_CYCLES);
    end else if (wr_busy) begin
      wr_cnt_q <= wr_cnt_q - TW'(1);
    end
  end

  assign status_out       = sfr_pkg::sfr_status_type'(status_q | {15'h0000, busy});
  assign cont_mode_active = cont_q;

  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  chk_swr_needs_wel: assert property (swr_end && !status_q[1] |=> $stable(status_q[15:2]) && !wr_busy)
    else $error("status write taken without write enable");
  chk_swr_bit_count: assert property (swr_end && !swr_short && !swr_long |=> $stable(status_q[15:2]))
    else $error("status write with wrong bit count changed status");
  chk_readonly_bits: assert property (swr_commit |=> status_q[15:10] == $past(status_q[15:10]))
    else $error("read-only status bits changed");
  chk_short_clears_hi: assert property (swr_commit && swr_short |=> status_q[9:8] == 2'b00)
    else $error("short status write kept upper bits");
  chk_busy_window: assert property (swr_commit |=> status_out.busy [*8])
    else $error("busy missing after status write");
  chk_wel_after_write: assert property ($fell(wr_busy) && !$past(write_enable_set) |-> !status_q[1])
    else $error("write enable latch kept after write cycle");
  chk_read_when_busy: assert property (cmd_done && busy && !op_stat && !op_swr |=> state_q == sfr_pkg::ST_SKIP)
    else $error("read accepted while busy");
  chk_quad_gate: assert property (cmd_done && op_quad && !quad_ok |=> state_q != sfr_pkg::ST_ADDR)
    else $error("quad read accepted without quad enable");
  chk_cont_frame: assert property (cs_fall && cont_q |=> state_q == sfr_pkg::ST_ADDR && dual_in_q)
    else $error("continuous frame did not start at address");
  chk_addr_step: assert property (push && cs_low && !addr_done |=> rd_addr_q == $past(rd_addr_q) + 24'h000001)
    else $error("read address did not advance");
  chk_dual_lanes: assert property (fall && in_data && dual |=> oe_q == 4'h3 && out_q[1] == $past(cur_byte[7]))
    else $error("dual data lane order wrong");
endmodule

// ==== bench/sfr_host.sv ====
/*
  spi host model, mode 0: drives serial clock, select and the four data lines.
  assumes callers enter its tasks just after a rising clk edge.
*/
`timescale 1ns/1ns
module sfr_host (
  input  wire logic       clk,
  input  wire logic [3:0] dev_out,
  input  wire logic [3:0] dev_oe,
  output logic            sclk,
  output logic            cs_n,
  output logic [3:0]      line
);
  logic [3:0] hout;
  logic [3:0] hoe;
  logic [3:0] float_q;
  initial begin
    sclk = 1'b0;
    cs_n = 1'b1;
    hout = 4'h0;
    hoe = 4'h0;
    float_q = 4'h0;
  end
  // released lines toggle so a stale level never passes for data
  always @(posedge clk) float_q <= ~float_q;
  always_comb begin
    for (int i = 0; i < 4; i++) begin
      line[i] = dev_oe[i] ? dev_out[i] : (hoe[i] ? hout[i] : float_q[i]);
    end
  end
  // one serial clock: 4 clk low, 4 clk high; lines sampled just after the rise
  task cyc(input logic [3:0] d, input logic [3:0] oe, output logic [3:0] q);
    sclk <= 1'b0;
    hout <= d;
    hoe <= oe;
    repeat (4) @(posedge clk);
    sclk <= 1'b1;
    #1 q = line;
    repeat (4) @(posedge clk);
  endtask
  task start;
    cs_n <= 1'b0;
    repeat (4) @(posedge clk);
  endtask
  task stop;
    sclk <= 1'b0;
    hoe <= 4'h0;
    repeat (4) @(posedge clk);
    cs_n <= 1'b1;
    repeat (8) @(posedge clk);
  endtask
endmodule

// ==== bench/testbench.sv ====
/*
  self-checking bench for the flash front end: status write and read family.
  assumes the host model above and an instant memory whose byte is addr ^ 5A.
*/
`timescale 1ns/1ns
module testbench;
  logic                    clk = 1'b0;
  logic                    rst, we, ext_busy, sclk, cs_n, rd_req, rd_ack, cont;
  logic [3:0]              line, dout, doe;
  logic [23:0]             rd_addr;
  logic [7:0]              rd_data;
  sfr_pkg::sfr_status_type st;
  int                      fail_count = 0;
  int                      n_tests = 0;
  sfr_core #(.WRITE_CYCLES(400), .FIFO_DEPTH(16)) sfr_core_i (.clk(clk), .rst(rst), .sclk_pin(sclk),
    .cs_n_pin(cs_n), .data_line_in(line), .data_line_out(dout), .data_line_oe(doe), .write_enable_set(we),
    .ext_busy(ext_busy), .status_out(st), .cont_mode_active(cont), .rd_req(rd_req), .rd_addr(rd_addr),
    .rd_ack(rd_ack), .rd_data(rd_data));
  sfr_host sfr_host_i (.clk(clk), .dev_out(dout), .dev_oe(doe), .sclk(sclk), .cs_n(cs_n), .line(line));
  // memory answers at once, so the fifo never starves the first byte
  assign rd_ack = rd_req;
  assign rd_data = rd_addr[7:0] ^ 8'h5A;
  always #50 clk = ~clk;
  task check(input logic [15:0] got, input logic [15:0] exp);
    n_tests++;
    if (got !== exp) begin
      fail_count++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task give_verdict;
    $display("comparisons %0d mismatches %0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  task send_bits(input logic [31:0] v, input int n);
    logic [3:0] q;
    sfr_host_i.start;
    for (int i = 0; i < n; i++) sfr_host_i.cyc({3'h0, v[31-i]}, 4'h1, q);
    sfr_host_i.stop;
  endtask
  // write cycle is long enough that a status read fits inside it
  task wait_ready;
    int k;
    for (k = 0; k < 1000 && st.busy !== 1'b0; k++) @(posedge clk);
    if (k == 1000) begin
      check({15'h0, st.busy}, 16'h0000);
      give_verdict;
    end
  endtask
  task read_status(input logic [7:0] op, output logic [7:0] r);
    logic [3:0] q;
    r = 8'h00;
    sfr_host_i.start;
    for (int i = 7; i >= 0; i--) sfr_host_i.cyc({3'h0, op[i]}, 4'h1, q);
    for (int i = 0; i < 8; i++) begin
      sfr_host_i.cyc(4'h0, 4'h0, q);
      r = {r[6:0], q[1]};
    end
    sfr_host_i.stop;
  endtask
  task set_wel;
    we <= 1'b1;
    @(posedge clk);
    we <= 1'b0;
    @(posedge clk);
  endtask
  // kind: 0 plain, 1 fast, 2 dual out, 3 quad out, 4 dual io
  task read_frame(input logic [7:0] op, input bit with_op, input int kind, input logic [23:0] a,
                  input logic [7:0] m, input int nb, input bit ok);
    logic [3:0] q;
    logic [7:0] r;
    int         w;
    w = (kind < 2) ? 1 : ((kind == 3) ? 4 : 2);
    r = 8'h00;
    sfr_host_i.start;
    for (int i = 7; i >= 0 && with_op; i--) sfr_host_i.cyc({3'h0, op[i]}, 4'h1, q);
    if (kind == 4) begin
      for (int i = 22; i >= 0; i -= 2) sfr_host_i.cyc({2'h0, a[i+:2]}, 4'h3, q);
      for (int i = 6; i >= 0; i -= 2) sfr_host_i.cyc({2'h0, m[i+:2]}, 4'h3, q);
    end else begin
      for (int i = 23; i >= 0; i--) sfr_host_i.cyc({3'h0, a[i]}, 4'h1, q);
      if (kind > 0) repeat (8) sfr_host_i.cyc(4'h0, 4'h0, q);
    end
    for (int b = 0; b < nb; b++) begin
      for (int c = 0; c < 8 / w; c++) begin
        sfr_host_i.cyc(4'h0, 4'h0, q);
        r = (w == 1) ? {r[6:0], q[1]} : ((w == 2) ? {r[5:0], q[1:0]} : {r[3:0], q});
        if (!ok) check({12'h0, doe}, 16'h0000);
      end
      if (ok) check({8'h0, r}, {8'h0, (a[7:0] + b[7:0]) ^ 8'h5A});
    end
    sfr_host_i.stop;
  endtask
  task t_reset;
    check(st, 16'h0000);
    check({15'h0, cont}, 16'h0000);
    $display("test reset done");
  endtask
  task t_wsr;
    logic [7:0] r;
    send_bits({8'h01, 16'hFFFF, 8'h00}, 24);
    check(st, 16'h0000);
    set_wel;
    send_bits({8'h01, 16'hFFFF, 8'h00}, 24);
    check({15'h0, st.busy}, 16'h0001);
    read_status(sfr_pkg::OP_STATUS_LO, r);
    check({8'h0, r}, 16'h00FF);
    wait_ready;
    check(st, 16'h03FC);
    read_status(sfr_pkg::OP_STATUS_HI, r);
    check({8'h0, r}, 16'h0003);
    set_wel;
    send_bits({8'h01, 8'hA5, 16'h0000}, 16);
    wait_ready;
    check(st, 16'h00A4);
    $display("test status write done");
  endtask
  task t_refused;
    set_wel;
    send_bits({8'h01, 16'hFFFF, 8'h00}, 20);
    check(st, 16'h00A6);
    send_bits(32'h01000000, 4);
    check(st, 16'h00A6);
    read_frame(sfr_pkg::OP_QUAD_OUT, 1'b1, 3, 24'h000100, 8'h00, 1, 1'b0);
    ext_busy <= 1'b1;
    read_frame(sfr_pkg::OP_READ, 1'b1, 0, 24'h000200, 8'h00, 1, 1'b0);
    ext_busy <= 1'b0;
    // let the released busy reach the status before looking at it
    @(posedge clk);
    check(st, 16'h00A6);
    $display("test refusals done");
  endtask
  task t_reads;
    read_frame(sfr_pkg::OP_READ, 1'b1, 0, 24'h123456, 8'h00, 3, 1'b1);
    read_frame(sfr_pkg::OP_FAST_READ, 1'b1, 1, 24'hABCD10, 8'h00, 2, 1'b1);
    read_frame(sfr_pkg::OP_DUAL_OUT, 1'b1, 2, 24'h0000C3, 8'h00, 2, 1'b1);
    read_frame(sfr_pkg::OP_DUAL_IO, 1'b1, 4, 24'h5A5A20, 8'hA5, 2, 1'b1);
    check({15'h0, cont}, 16'h0001);
    read_frame(8'h00, 1'b0, 4, 24'h3C3C40, 8'h5F, 2, 1'b1);
    check({15'h0, cont}, 16'h0000);
    read_frame(sfr_pkg::OP_FAST_READ, 1'b1, 1, 24'h000080, 8'h00, 1, 1'b1);
    $display("test reads done");
  endtask
  task t_quad;
    set_wel;
    send_bits({8'h01, 16'h0003, 8'h00}, 24);
    wait_ready;
    check(st, 16'h0300);
    read_frame(sfr_pkg::OP_QUAD_OUT, 1'b1, 3, 24'h0A0B10, 8'h00, 2, 1'b1);
    $display("test quad done");
  endtask
  initial begin
    rst = 1'b1;
    we = 1'b0;
    ext_busy = 1'b0;
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    repeat (4) @(posedge clk);
    t_reset;
    t_wsr;
    t_refused;
    t_reads;
    t_quad;
    give_verdict;
  end
endmodule
